/* verilog/sdcp_top.sv */
// Sample clock divider with per-channel phase offset and its registers
`timescale 1ns/1ps
`default_nettype none
module sdcp_top
    import sdcp_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire sdcp_reg_req_s       reg_req,
    input  wire logic [NUM_CH-1:0]   reg_chan_sel,
    output logic      [DATA_W-1:0]   reg_rdata,
    output logic      [NUM_CH-1:0]   ch_clk,
    output logic                     div_lvl
);

    typedef struct packed {
        logic [DIV_W-1:0]             div_code;
        logic [DIV_W-1:0]             cnt;
        logic                         lvl;
        logic [DATA_W-1:0]            rdata;
        logic [NUM_CH-1:0][PH_W-1:0]  phase;
    } sdcp_state_s;

    sdcp_state_s     st_ff;
    sdcp_state_s     nxt_st;
    logic [DIV_W-1:0] half;
    logic [DIV_W-1:0] cnt_inc;
    logic            code_ok;
    logic [PH_W-1:0] rd_phase;

    // Only the four documented ratios are accepted
    always_comb begin
        code_ok = (reg_req.wdata[DIV_W-1:0] == DIV_BY_1)
               || (reg_req.wdata[DIV_W-1:0] == DIV_BY_2)
               || (reg_req.wdata[DIV_W-1:0] == DIV_BY_4)
               || (reg_req.wdata[DIV_W-1:0] == DIV_BY_8);
    end

    // Readback picks the lowest selected channel, channel 0 if none
    always_comb begin
        rd_phase = st_ff.phase[0];
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (reg_chan_sel[i]) begin
                rd_phase = st_ff.phase[i];
            end
        end
    end

    // Code doubles as wrap mask: 000, 001, 011, 111 give 1, 2, 4, 8
    always_comb begin
        nxt_st  = st_ff;
        half    = (st_ff.div_code >> 1) + CNT_ONE;
        cnt_inc = (st_ff.cnt + CNT_ONE) & st_ff.div_code;
        nxt_st.cnt = cnt_inc;
        nxt_st.lvl = cnt_inc < half;
        if (reg_req.wr && reg_req.addr == ADDR_DIV_CTRL && code_ok) begin
            // Restart the count so the new ratio starts on a clean edge
            nxt_st.div_code = reg_req.wdata[DIV_W-1:0];
            nxt_st.cnt      = CNT_RESET;
            nxt_st.lvl      = 1'b1;
        end
        if (reg_req.wr && reg_req.addr == ADDR_PHASE) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_chan_sel[i]) begin
                    nxt_st.phase[i] = reg_req.wdata[PH_W-1:0];
                end
            end
        end
        // Reserved bits read as zero; unmapped addresses read zero
        unique case (reg_req.addr)
            ADDR_DIV_CTRL: nxt_st.rdata = {5'h00, st_ff.div_code};
            ADDR_PHASE:    nxt_st.rdata = {4'h0, rd_phase};
            default:       nxt_st.rdata = 8'h00;
        endcase
    end

    // Reset lands on divide-by-2 with no phase offset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff.div_code <= DIV_RESET;
            st_ff.cnt      <= CNT_RESET;
            st_ff.lvl      <= 1'b1;
            st_ff.rdata    <= 8'h00;
            st_ff.phase    <= {NUM_CH{PHASE_RESET}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign div_lvl   = st_ff.lvl;

    // One delay line per channel, all fed by the shared divider
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        sdcp_phase_dly u_dly (
            .clk     (clk),
            .rst     (rst),
            .div_lvl (st_ff.lvl),
            .bypass  (st_ff.div_code == DIV_BY_1),
            .phase   (st_ff.phase[g]),
            .ch_clk  (ch_clk[g])
        );
    end

    chk_div8_wrap: assert property (@(posedge clk) disable iff (rst)
        (st_ff.div_code == DIV_BY_8 && st_ff.cnt == 3'h7 && !reg_req.wr)
        |=> st_ff.cnt == 3'h0 && st_ff.lvl)
        else $error("divide-by-8 count did not wrap after 8");
    chk_div4_level: assert property (@(posedge clk) disable iff (rst)
        (st_ff.div_code == DIV_BY_4 && st_ff.cnt == 3'h1 && !reg_req.wr)
        |=> st_ff.cnt == 3'h2 && !st_ff.lvl)
        else $error("divide-by-4 level not low in second half");
    chk_div_legal: assert property (@(posedge clk) disable iff (rst)
        st_ff.div_code == DIV_BY_1 || st_ff.div_code == DIV_BY_2
        || st_ff.div_code == DIV_BY_4 || st_ff.div_code == DIV_BY_8)
        else $error("divider holds an undefined code");

endmodule
`default_nettype wire

/* verilog/sdcp_pkg.sv */
// Constants and carrier types for the sample clock divider and phase block
package sdcp_pkg;

    localparam int unsigned NUM_CH   = 4;     // Converter channels
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned DIV_W    = 3;
    localparam int unsigned PH_W     = 4;
    localparam int unsigned MAX_WHOLE = 8;    // Whole-cycle taps incl. zero

    localparam logic [ADDR_W-1:0] ADDR_DIV_CTRL = 16'h0108;
    localparam logic [ADDR_W-1:0] ADDR_PHASE    = 16'h0109;

    localparam logic [DIV_W-1:0] DIV_BY_1 = 3'h0;
    localparam logic [DIV_W-1:0] DIV_BY_2 = 3'h1;
    localparam logic [DIV_W-1:0] DIV_BY_4 = 3'h3;
    localparam logic [DIV_W-1:0] DIV_BY_8 = 3'h7;

    localparam logic [DIV_W-1:0] DIV_RESET   = DIV_BY_2;
    localparam logic [PH_W-1:0]  PHASE_RESET = 4'h0;
    localparam logic [DIV_W-1:0] CNT_RESET   = 3'h0;
    localparam logic [DIV_W-1:0] CNT_ONE     = 3'h1;

    // Register write/read request from the control port
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sdcp_reg_req_s;

endpackage

/* verilog/sdcp_phase_dly.sv */
// One channel: delays the divided clock in half input-cycle steps
`timescale 1ns/1ps
`default_nettype none
module sdcp_phase_dly
    import sdcp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            div_lvl,
    input  wire logic            bypass,
    input  wire logic [PH_W-1:0] phase,
    output logic                 ch_clk
);

    typedef struct packed {
        logic [MAX_WHOLE-2:0] sh;
        logic [PH_W-1:0]      last_ph;
        logic [PH_W-1:0]      age;
    } sdcp_dly_state_s;

    sdcp_dly_state_s st_ff;
    sdcp_dly_state_s nxt_st;
    logic            tap;
    logic            neg_ff;
    logic [PH_W-2:0] whole;

    assign whole = phase[PH_W-1:1];

    // Whole-cycle tap; zero picks the undelayed level
    always_comb begin
        tap = div_lvl;
        if (whole != 3'h0) begin
            tap = st_ff.sh[whole - 3'h1];
        end
    end

    // Shift line plus an age counter that only the checks read
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.sh      = {st_ff.sh[MAX_WHOLE-3:0], div_lvl};
        nxt_st.last_ph = phase;
        if (phase != st_ff.last_ph) begin
            nxt_st.age = 4'h0;
        end else if (st_ff.age != 4'hF) begin
            nxt_st.age = st_ff.age + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Half step taken on the inverted clock edge
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            neg_ff <= 1'b0;
        end else begin
            neg_ff <= tap;
        end
    end

    // Divide-by-1 has no level to delay, so inversion is the only step
    always_comb begin
        if (bypass) begin
            ch_clk = phase[0] ? ~clk : clk;
        end else if (phase[0]) begin
            ch_clk = neg_ff;
        end else begin
            ch_clk = tap;
        end
    end

    chk_zero_delay: assert property (@(posedge clk) disable iff (rst)
        (phase == 4'h0 && !bypass) |-> ch_clk == div_lvl)
        else $error("zero offset does not pass divided clock");
    chk_one_cycle: assert property (@(posedge clk) disable iff (rst)
        (phase == 4'h2 && st_ff.age >= 4'h1 && !bypass)
        |-> ch_clk == $past(div_lvl))
        else $error("offset 2 is not one cycle late");
    // Half step only shows on the falling edge: output lags one fall
    chk_half_step: assert property (@(negedge clk) disable iff (rst)
        (phase == 4'h1 && $stable(phase) && !bypass)
        |-> ch_clk == $past(div_lvl))
        else $error("offset 1 not taken from inverted edge");
    // Odd codes seen at a rising edge already carry the extra half step
    chk_odd_nine: assert property (@(posedge clk) disable iff (rst)
        (phase == 4'h9 && st_ff.age >= 4'h6 && !bypass)
        |-> ch_clk == $past(div_lvl, 4))
        else $error("offset 9 is not four and a half cycles late");
    chk_max_offset: assert property (@(posedge clk) disable iff (rst)
        (phase == 4'hF && st_ff.age >= 4'h9 && !bypass)
        |-> ch_clk == $past(div_lvl, 7))
        else $error("offset 15 is not seven and a half cycles late");

endmodule
`default_nettype wire

/* tb/sample_clock_divider_phase_tb.sv */
// Self-checking bench for the clock divider and per-channel phase offsets
`timescale 1ns/1ps
`default_nettype none
module sample_clock_divider_phase_tb
    import sdcp_pkg::*;
;
    logic                clk          = 1'b0;
    logic                rst          = 1'b1;
    sdcp_reg_req_s       reg_req      = '0;
    logic [NUM_CH-1:0]   reg_chan_sel = 4'h1;
    logic [DATA_W-1:0]   reg_rdata;
    logic [NUM_CH-1:0]   ch_clk;
    logic                div_lvl;
    logic [15:0]         hist         = 16'h0000;
    logic [DATA_W-1:0]   rd;
    int                  miscompares  = 0;
    int                  n_tests      = 0;
    int                  cycles       = 0;
    int                  p;

    sdcp_top i_dut (
        .clk          (clk),
        .rst          (rst),
        .reg_req      (reg_req),
        .reg_chan_sel (reg_chan_sel),
        .reg_rdata    (reg_rdata),
        .ch_clk       (ch_clk),
        .div_lvl      (div_lvl)
    );

    // 250 MHz input clock
    always #2 clk = ~clk;

    // Undelayed level history, one entry per half cycle, newest first
    always @(clk) begin
        #1;
        hist <= {hist[14:0], div_lvl};
    end

    // Hang guard; the full scan needs well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write strobe is one cycle wide, settings land at the next edge
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        @(posedge clk);
        reg_req.wr    <= 1'b0;
    endtask

    // Read data is registered, so allow two full cycles after the address
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        @(posedge clk);
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // Cycles between two first-high samples of the divided level
    task automatic period(output int n);
        n = 0;
        while (div_lvl !== 1'b0 && n < 20) begin @(posedge clk); n++; end
        while (div_lvl !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        n = 0;
        while (div_lvl !== 1'b0 && n < 20) begin @(posedge clk); n++; end
        while (div_lvl !== 1'b1 && n < 40) begin @(posedge clk); n++; end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reg_rd(ADDR_DIV_CTRL, rd); check(rd, 8'h01);
        reg_rd(ADDR_PHASE, rd);    check(rd, 8'h00);
        period(p);                 check(8'(p), 8'h02);
        // Divider codes 001, 011 and 111, read back and timed
        for (int i = 1; i <= 3; i++) begin
            reg_wr(ADDR_DIV_CTRL, 8'((1 << i) - 1));
            reg_rd(ADDR_DIV_CTRL, rd); check(rd, 8'((1 << i) - 1));
            period(p);                 check(8'(p), 8'(1 << i));
        end
        // Illegal code kept out, upper bits dropped, unmapped reads zero
        reg_wr(ADDR_DIV_CTRL, 8'h02);
        reg_rd(ADDR_DIV_CTRL, rd); check(rd, 8'h07);
        reg_wr(ADDR_PHASE, 8'hF5);
        reg_rd(ADDR_PHASE, rd);    check(rd, 8'h05);
        reg_rd(16'h010A, rd);      check(rd, 8'h00);
        // Divide-by-1: channel 0 inverted, channel 1 follows the clock
        reg_wr(ADDR_DIV_CTRL, 8'h00);
        reg_wr(ADDR_PHASE, 8'h01);
        @(posedge clk); #1 check({6'h00, ch_clk[1:0]}, 8'h02);
        #2 check({6'h00, ch_clk[1:0]}, 8'h01);
        // Every phase code on channel 0 at divide-by-8, others at zero
        reg_wr(ADDR_DIV_CTRL, 8'h07);
        for (int k = 0; k < 16; k++) begin
            reg_wr(ADDR_PHASE, 8'(k));
            reg_rd(ADDR_PHASE, rd); check(rd, 8'(k));
            repeat (20) @(posedge clk);
            repeat (32) begin
                @(clk);
                #1.5 check({4'h0, ch_clk},
                    {4'h0, {3{div_lvl}}, hist[k]});
            end
        end
        // Channel mask selects which channels a write reaches
        @(posedge clk);
        reg_chan_sel <= 4'h6;
        reg_wr(ADDR_PHASE, 8'h09);
        repeat (20) @(posedge clk);
        // Channels 1 and 2 now at 4.5 cycles, 0 at 7.5, 3 undelayed
        @(clk);
        #1.5 check({4'h0, ch_clk},
            {4'h0, div_lvl, hist[9], hist[9], hist[15]});
        @(posedge clk);
        reg_chan_sel <= 4'h2;
        reg_rd(ADDR_PHASE, rd);    check(rd, 8'h09);
        @(posedge clk);
        reg_chan_sel <= 4'h1;
        reg_rd(ADDR_PHASE, rd);    check(rd, 8'h0F);
        // Reset in mid-run restores divide-by-2 and zero offset
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_rd(ADDR_DIV_CTRL, rd); check(rd, 8'h01);
        reg_rd(ADDR_PHASE, rd);    check(rd, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
